// [srhh_pkg.sv]
/*
 * Shared constants and types for the step-rate, hold-current and homing block:
 * APB register offsets, field positions, reset values and timing counts.
 * Assumes a single 250 MHz system clock and a 32-bit APB register bus.
 */
package srhh_pkg;

   // Clock rate and the derived 10 ms hold tick.
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned CLK_HZ       = CLK_MHZ * 1000000;
   localparam int unsigned TICK_MS      = 10;
   localparam int unsigned TICK_CYC_DEF = CLK_MHZ * 1000 * TICK_MS;

   // Register byte offsets.
   localparam logic [7:0] OFS_DIV    = 8'h00;
   localparam logic [7:0] OFS_HOLD   = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_HOME   = 8'h0C;
   localparam logic [7:0] OFS_IVEL   = 8'h10;
   localparam logic [7:0] OFS_ACCEL  = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // Field positions.
   localparam int unsigned CTRL_INV_BIT   = 0;
   localparam int unsigned CTRL_STORE_BIT = 1;
   localparam int unsigned HOME_DIR_BIT   = 16;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_RUN_BIT     = 1;
   localparam int unsigned ST_HACT_BIT    = 2;

   // Reset values and limits.
   localparam logic [7:0]  DIV_RST     = 8'h04;
   localparam logic [7:0]  HOLD_RST    = 8'h64;
   localparam logic [7:0]  HOLD_MIN    = 8'h05;
   localparam logic [7:0]  HOLD_OFF    = 8'hFF;
   localparam logic [14:0] IVEL_RST    = 15'h07D0;
   localparam logic [14:0] ACCEL_RST   = 15'h0010;
   localparam logic [14:0] VEL_MAX     = 15'h7D00;
   localparam logic [27:0] STEP_ACC_TOP = 28'(CLK_HZ);

   // Homing sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACCEL,
      ST_SLEW,
      ST_DECEL,
      ST_REV
   } srhh_state_t;

endpackage : srhh_pkg

// [srhh_stepgen.sv]
/*
 * Step-rate generator: a prescaler divides the clock by the speed divider,
 * and a phase accumulator turns the rate in steps per second into pulses.
 * Assumes rate and divider come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module srhh_stepgen
   import srhh_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic [14:0] rate_i,
   input  wire logic [7:0]  div_i,
   output logic             step_o
);

   logic [7:0]  pre_cnt;
   logic [27:0] acc;
   logic [27:0] next_acc;
   logic        pre_tick;

   // Divider of one gives a tick every clock, so the rate passes unchanged.
   assign pre_tick = (pre_cnt >= div_i - 8'h01);
   assign next_acc = acc + {13'h0000, rate_i};

   // Prescaler; cleared while idle so every motion starts from a clean phase.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_cnt <= 8'h00;
      end else if (!en_i || pre_tick) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   // Accumulator wraps at the clock rate, giving rate/div steps per second.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc    <= 28'h0000000;
         step_o <= 1'b0;
      end else if (!en_i) begin
         acc    <= 28'h0000000;
         step_o <= 1'b0;
      end else if (pre_tick) begin
         step_o <= (next_acc >= STEP_ACC_TOP);
         acc    <= (next_acc >= STEP_ACC_TOP) ? next_acc - STEP_ACC_TOP : next_acc;
      end else begin
         step_o <= 1'b0;
      end
   end

endmodule : srhh_stepgen

`default_nettype wire

// [srhh_top.sv]
/*
 * Speed divider, hold-current timer and two-stage homing for one stepper axis.
 * Assumes an APB master on REF_CLK_I and a home switch on an asynchronous pin.
 */
`timescale 1ns/10ps
`default_nettype none

module srhh_top
   import srhh_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF
)
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        HOME_I,
   output logic             STEP_O,
   output logic             DIR_O,
   output logic             RUN_CUR_O,
   output logic             BUSY_O,
   output logic             STORE_O
);

   logic [7:0]  div;
   logic [7:0]  hold_dly;
   logic        home_inv;
   logic [14:0] ivel;
   logic [14:0] accel;
   logic [14:0] home_spd;
   logic [14:0] vel;
   logic [7:0]  hold_cnt;
   logic        armed;
   logic [21:0] tick_cnt;
   logic        tick;
   logic        home_s1;
   logic        home_s2;
   logic        home_act;
   logic        wr_en;
   logic        mapped;
   logic        step_pulse;
   logic        gen_en;
   logic        home_go;
   logic [15:0] vel_up;
   logic [31:0] rd_mux;
   srhh_state_t state;

   assign wr_en   = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   assign mapped  = (PADDR_I == OFS_DIV) || (PADDR_I == OFS_HOLD) || (PADDR_I == OFS_CTRL) ||
                    (PADDR_I == OFS_HOME) || (PADDR_I == OFS_IVEL) ||
                    (PADDR_I == OFS_ACCEL) || (PADDR_I == OFS_STATUS);
   // A homing request is refused while a search is already running.
   // One entry point.
   assign home_go = wr_en && (PADDR_I == OFS_HOME) && (state == ST_IDLE) &&
                    (PWDATA_I[14:0] != 15'h0000);
   assign vel_up  = {1'b0, vel} + {1'b0, accel};

   // Read data multiplexer; reserved bits read as zero.
   // Divider readback.
   always_comb begin
      case (PADDR_I)
         OFS_DIV:    rd_mux = {24'h000000, div};
         OFS_HOLD:   rd_mux = {24'h000000, hold_dly};
         OFS_CTRL:   rd_mux = {31'h00000000, home_inv};
         OFS_HOME:   rd_mux = {15'h0000, DIR_O, 1'b0, home_spd};
         OFS_IVEL:   rd_mux = {17'h00000, ivel};
         OFS_ACCEL:  rd_mux = {17'h00000, accel};
         OFS_STATUS: rd_mux = {29'h00000000, home_act, RUN_CUR_O, BUSY_O};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   // APB slave: one wait-free access phase, answer latched in the setup cycle.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end else begin
         PREADY_O  <= PSEL_I & ~PENABLE_I & ~PREADY_O;
         PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped;
         PRDATA_O  <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_mux : 32'h00000000;
      end
   end

   // Working parameter registers; nothing here survives power loss.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         div      <= DIV_RST;
         hold_dly <= HOLD_RST;
         home_inv <= 1'b0;
         ivel     <= IVEL_RST;
         accel    <= ACCEL_RST;
      end else if (wr_en) begin
         if (PADDR_I == OFS_DIV && PWDATA_I[31:8] == 24'h000000 &&
             PWDATA_I[7:0] != 8'h00) begin
            div <= PWDATA_I[7:0];
         end
         if (PADDR_I == OFS_HOLD) begin
            if (PWDATA_I[31:8] != 24'h000000 || PWDATA_I[7:0] < HOLD_MIN) begin
               hold_dly <= HOLD_RST;
            end else begin
               hold_dly <= PWDATA_I[7:0];
            end
         end
         if (PADDR_I == OFS_CTRL) begin
            home_inv <= PWDATA_I[CTRL_INV_BIT];
         end
         if (PADDR_I == OFS_IVEL && PWDATA_I[14:0] <= VEL_MAX) begin
            ivel <= PWDATA_I[14:0];
         end
         if (PADDR_I == OFS_ACCEL && PWDATA_I[14:0] != 15'h0000) begin
            accel <= PWDATA_I[14:0];
         end
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         STORE_O <= 1'b0;
      end else begin
         STORE_O <= wr_en && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_STORE_BIT];
      end
   end

   // Two-flop synchroniser for the home pin; only the second stage is used.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         home_s1 <= 1'b1;
         home_s2 <= 1'b1;
      end else begin
         home_s1 <= HOME_I;
         home_s2 <= home_s1;
      end
   end

   assign home_act = ~home_s2 ^ home_inv;

   // Step generator runs in every moving state, but is cut in the same cycle
   // that the reverse creep sees the switch release, so no extra step leaks.
   // Stop on release.
   assign gen_en = (state != ST_IDLE) && !((state == ST_REV) && !home_act);

   srhh_stepgen u_stepgen (
      .clk_i  (REF_CLK_I),
      .rst_i  (RST_I),
      .en_i   (gen_en),
      .rate_i (vel),
      .div_i  (div),
      .step_o (step_pulse)
   );

   // Homing sequencer. Velocity changes by the slope on every ramp step, so the
   // speed quantum seen at the motor is slope/div: a larger divider walks a
   // ramp through the same number of smaller speed steps.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state    <= ST_IDLE;
         vel      <= IVEL_RST;
         home_spd <= 15'h0000;
         DIR_O    <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               vel <= ivel;
               if (home_go) begin
                  home_spd <= PWDATA_I[14:0];
                  DIR_O    <= PWDATA_I[HOME_DIR_BIT];
                  state    <= (ivel >= PWDATA_I[14:0]) ? ST_SLEW : ST_ACCEL;
                  vel      <= (ivel >= PWDATA_I[14:0]) ? PWDATA_I[14:0] : ivel;
               end
            end
            ST_ACCEL: begin
               if (home_act) begin
                  state <= ST_DECEL;
               end else if (step_pulse) begin
                  if (vel_up >= {1'b0, home_spd}) begin
                     vel   <= home_spd;
                     state <= ST_SLEW;
                  end else begin
                     vel <= vel_up[14:0];
                  end
               end
            end
            ST_SLEW: begin
               if (home_act) begin
                  state <= ST_DECEL;
               end
            end
            ST_DECEL: begin
               // Slow down, then reverse.
               // The turn waits for a cycle without a step pulse, so DIR_O never
               // changes while STEP_O is high and the last slowing step keeps its way.
               if (vel <= ivel || vel - ivel <= accel) begin
                  if (!step_pulse) begin
                     vel   <= ivel;
                     DIR_O <= ~DIR_O;
                     state <= ST_REV;
                  end
               end else if (step_pulse) begin
                  vel <= vel - accel;
               end
            end
            ST_REV: begin
               if (!home_act) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Step and busy outputs straight from flops.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         STEP_O <= 1'b0;
         BUSY_O <= 1'b0;
      end else begin
         STEP_O <= step_pulse;
         BUSY_O <= (state != ST_IDLE) || home_go;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_cnt <= 22'h000000;
         tick     <= 1'b0;
      end else if (tick_cnt == 22'(TICK_CYC - 1)) begin
         tick_cnt <= 22'h000000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 22'h000001;
         tick     <= 1'b0;
      end
   end

   // Hold countdown. The free-running tick means the first decrement may come
   // early, so the real delay lies between (t-1) and t ticks.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RUN_CUR_O <= 1'b1;
         armed     <= 1'b0;
         hold_cnt  <= 8'h00;
      end else if (step_pulse || state != ST_IDLE) begin
         RUN_CUR_O <= 1'b1;
         armed     <= 1'b1;
         hold_cnt  <= hold_dly;
      end else if (armed && tick) begin
         if (hold_cnt <= 8'h01) begin
            armed <= 1'b0;
            if (hold_dly != HOLD_OFF) begin
               RUN_CUR_O <= 1'b0;
            end
         end else begin
            hold_cnt <= hold_cnt - 8'h01;
         end
      end
   end

   // Checks kept beside the logic they guard.
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   a_div_nonzero: assert property (div != 8'h00)
      else $error("Divider reached zero.");
   a_div_write: assert property (wr_en && PADDR_I == OFS_DIV && PWDATA_I[31:8] == 24'h000000
      && PWDATA_I[7:0] != 8'h00 |=> div == $past(PWDATA_I[7:0]))
      else $error("Divider write not applied next cycle.");
   a_div_read: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == OFS_DIV
      |=> PREADY_O && PRDATA_O == {24'h000000, div})
      else $error("Divider readback wrong.");
   a_hold_reject: assert property (wr_en && PADDR_I == OFS_HOLD && PWDATA_I < 32'h00000005
      |=> hold_dly == HOLD_RST)
      else $error("Short hold delay not replaced by default.");
   a_hold_write: assert property (wr_en && PADDR_I == OFS_HOLD && PWDATA_I >= 32'h00000005
      && PWDATA_I <= 32'h000000FF |=> hold_dly == $past(PWDATA_I[7:0]))
      else $error("Hold delay write not applied.");
   a_hold_off: assert property ($fell(RUN_CUR_O) |->
      $past(hold_dly) != HOLD_OFF && $past(tick))
      else $error("Hold current taken while disabled or off tick.");
   a_run_step: assert property (STEP_O |-> RUN_CUR_O ##1 RUN_CUR_O)
      else $error("Hold current while stepping.");
   a_store_pulse: assert property (STORE_O |=> !STORE_O)
      else $error("Store strobe longer than one cycle.");
   a_home_decel: assert property ((state == ST_SLEW || state == ST_ACCEL) && home_act
      |=> state == ST_DECEL)
      else $error("No deceleration on home active.");
   a_rev_stop: assert property (state == ST_REV && !home_act |-> !gen_en ##1 state == ST_IDLE
      ##1 !STEP_O)
      else $error("Steps after home release.");
   a_home_sense: assert property (home_act == (!$past(HOME_I, 2) ^ home_inv))
      else $error("Home sense wrong.");

   c_home_done: cover property (state == ST_REV ##1 state == ST_IDLE);
   c_hold_drop: cover property ($fell(RUN_CUR_O));
   c_hold_reject: cover property (wr_en && PADDR_I == OFS_HOLD && PWDATA_I > 32'h000000FF);
   c_slew_reached: cover property (state == ST_ACCEL ##1 state == ST_SLEW);

endmodule : srhh_top

`default_nettype wire

// [srhh_axis_model.sv]
/*
 * Far side of the axis: a stepper driver that tracks position from step and
 * direction, and a home switch operated outside a band of that position.
 * Assumes one-cycle step pulses sampled on the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module srhh_axis_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic step_i,
   input  wire logic dir_i,
   input  wire logic inv_i,
   output logic      home_o,
   output var int    pos_o,
   output var int    steps_o
);
   logic active;

   // The driver moves one step per pulse; direction 1 is negative.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pos_o   <= 0;
         steps_o <= 0;
      end else if (step_i) begin
         pos_o   <= dir_i ? pos_o - 1 : pos_o + 1;
         steps_o <= steps_o + 1;
      end
   end

   // The switch is operated two steps out and below zero, so that both
   // homing directions meet it within a few steps and the run stays short.
   assign active = (pos_o >= 2) || (pos_o <= -1);

   // switch wiring.
   // A normally open contact grounds the pulled-up pin when operated; a
   // normally closed one releases it, so the pin then rises.
   assign home_o = inv_i ? active : !active;
endmodule : srhh_axis_model
`default_nettype wire

// [step_rate_hold_and_homing_tb.sv]
/*
 * Self-checking bench for the step-rate, hold-current and homing block.
 * Assumes a short hold tick; the APB task waits for ready however long it takes.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
   begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

module step_rate_hold_and_homing_tb;
   import srhh_pkg::*;

   localparam int unsigned TICK  = 20;
   localparam int          LIMIT = 95000;
   localparam logic [31:0] DV [3] = '{32'h1, 32'hFF, 32'h0};
   localparam logic [31:0] DX [3] = '{32'h1, 32'hFF, 32'hFF};
   localparam logic [31:0] HV [5] = '{32'h4, 32'h100, 32'h5, 32'hFF, 32'h5};
   localparam logic [31:0] HX [5] = '{32'h64, 32'h64, 32'h5, 32'hFF, 32'h5};

   logic        clk, rst, psel, penable, pwrite, inv, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdata, prdata;
   logic        pready, pslverr, home, step, dir, run_cur, busy, store;
   int          fail_count, checks_done, cyc, store_cnt, pos, steps;

   srhh_top #(.TICK_CYC(TICK)) dut_u (
      .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .HOME_I(home), .STEP_O(step),
      .DIR_O(dir), .RUN_CUR_O(run_cur), .BUSY_O(busy), .STORE_O(store));

   srhh_axis_model axis_u (
      .clk_i(clk), .rst_i(rst), .step_i(step), .dir_i(dir), .inv_i(inv),
      .home_o(home), .pos_o(pos), .steps_o(steps));

   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Cycle count, store strobes seen, and the cut-off for a hung run.
   always @(posedge clk) begin
      cyc++;
      if (store === 1'b1) store_cnt++;
      if (cyc == LIMIT) begin
         fail_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         finish_test();
      end
   end

   // One APB transfer; the request stands until ready is seen high at a rising
   // edge, where read data are taken and only then the request is released.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // A write, then a read compared against the expected word.
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] w, input logic [31:0] e);
      apb(1'b1, a, w);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, e)
   endtask : wr_rd

   // One homing run: start, first step, slew period, then the final stop.
   task automatic home_run(input logic [31:0] cmd, input int first, input logic d0,
                           input int lo, input int hi, input int fin);
      int base;
      int t0;
      base = steps;
      apb(1'b1, OFS_HOME, cmd);
      @(negedge clk);
      `CHK(busy, 1'b1)
      while (steps < base + 1) @(negedge clk);
      t0 = cyc;
      `CHK(run_cur, 1'b1)
      `CHK(pos, first)
      `CHK(dir, d0)
      while (steps < base + 2) @(negedge clk);
      `CHK((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1)
      while (busy !== 1'b0) @(negedge clk);
      `CHK(pos, fin)
      `CHK(dir, !d0)
   endtask : home_run

   // Prints the verdict and ends the run.
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // Main sequence.
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      inv = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK(run_cur, 1'b1)
      apb(1'b0, OFS_DIV, 32'h0);
      `CHK(rdata, 32'h4)
      apb(1'b0, OFS_HOLD, 32'h0);
      `CHK(rdata, 32'h64)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rdata, 32'h2)
      for (int i = 0; i < 3; i++) wr_rd(OFS_DIV, DV[i], DX[i]);
      for (int i = 0; i < 5; i++) wr_rd(OFS_HOLD, HV[i], HX[i]);
      `CHK(store_cnt, 0)
      apb(1'b1, OFS_CTRL, 32'h2);
      // The strobe is counted at the edge after the write lands.
      repeat (2) @(negedge clk);
      `CHK(store_cnt, 1)
      apb(1'b0, 8'h1C, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, OFS_DIV, 32'h1);
      // one ramp step: start at 31000, slope 1000, up to 32000.
      apb(1'b1, OFS_IVEL, 32'h7918);
      apb(1'b1, OFS_ACCEL, 32'h3E8);
      home_run(32'h0000_7D00, 1, 1'b0, 7812, 7813, 1);
      repeat (70) @(negedge clk);
      `CHK(run_cur, 1'b1)
      repeat (45) @(negedge clk);
      `CHK(run_cur, 1'b0)
      apb(1'b1, OFS_HOLD, 32'hFF);
      apb(1'b1, OFS_DIV, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h1);
      inv <= 1'b1;
      home_run(32'h0001_7D00, 0, 1'b1, 15624, 15626, 0);
      // Longer than 255 ticks, so a countdown from 255 would already have ended.
      repeat (5200) @(negedge clk);
      `CHK(run_cur, 1'b1)
      finish_test();
   end
endmodule : step_rate_hold_and_homing_tb
`default_nettype wire
